/* File: rtl/chgst_regs.svh */
/*
 * Register offsets, field positions, reset values and the bus address of the
 * charger status register bank.
 * Assumes it is included by bare name from the design module and the testbench.
 */
`ifndef CHGST_REGS_SVH
`define CHGST_REGS_SVH

// Register offsets as seen on the two-wire serial port.
`define CHGST_OFS_INT_FLAGS 8'h01
`define CHGST_OFS_STAT_A    8'h02
`define CHGST_OFS_STAT_B    8'h03

// Reset value shared by both status registers and the change-flag register.
`define CHGST_RESET_VALUE   8'h00

// Seven-bit serial bus address of the device; the value is arbitrary.
`define CHGST_BUS_ADDR      7'h2A

// Bit positions inside the change-flag register.
`define CHGST_FLAG_THM      0
`define CHGST_FLAG_CHG      1
`define CHGST_FLAG_CHARGE_INPUT_PIN    2
`define CHGST_FLAG_TJ       3
`define CHGST_FLAG_CTRL     4
`define CHGST_FLAG_SYS      5

// Bits in one serial byte, sized to the width of the bit counter.
`define CHGST_BYTE_BITS     4'h8

`endif

/* File: rtl/chgst_pkg.sv */
/*
 * Types of the charger status register bank: code enumerations, the raw
 * status bundle from the analog loops and the two register layouts.
 * Assumes the offsets and field positions live in chgst_regs.svh.
 */
package chgst_pkg;

   // Battery thermistor zone codes; 3'h6 and 3'h7 are reserved.
   typedef enum logic [2:0] {
      ZONE_DISABLED = 3'h0,
      ZONE_COLD     = 3'h1,
      ZONE_COOL     = 3'h2,
      ZONE_WARM     = 3'h3,
      ZONE_HOT      = 3'h4,
      ZONE_NORMAL   = 3'h5
   } chgst_zone_t;

   // Charger state machine codes; 4'hD to 4'hF are reserved.
   typedef enum logic [3:0] {
      CHG_OFF        = 4'h0,
      CHG_PREQUAL    = 4'h1,
      CHG_CC         = 4'h2,
      CHG_CC_MOD     = 4'h3,
      CHG_CV         = 4'h4,
      CHG_CV_MOD     = 4'h5,
      CHG_TOPOFF     = 4'h6,
      CHG_TOPOFF_MOD = 4'h7,
      CHG_DONE       = 4'h8,
      CHG_DONE_MOD   = 4'h9,
      CHG_FAULT_PQ   = 4'hA,
      CHG_FAULT_FC   = 4'hB,
      CHG_FAULT_TEMP = 4'hC
   } chgst_chg_t;

   // Charge input qualification codes.
   typedef enum logic [1:0] {
      QUAL_UVLO     = 2'h0,
      QUAL_OVP      = 2'h1,
      QUAL_DEBOUNCE = 2'h2,
      QUAL_OK       = 2'h3
   } chgst_qual_t;

   // Raw status levels from the analog loops and the charger controller.
   typedef struct packed {
      logic        inputMinVoltageLoopActive;
      logic        inputCurrentLimitActive;
      logic        systemMinVoltageLoopActive;
      logic        dieTempLoopActive;
      logic [2:0]  batteryTempZone;
      logic [3:0]  chargerStateCode;
      chgst_qual_t inputQualificationCode;
      logic        charging;
      logic        chargeTimerSuspended;
      logic        thermistorEnable;
      logic        chargerEnable;
   } chgst_raw_t;

   // Layout of the loop and thermal status register.
   typedef struct packed {
      logic        unusedBit;
      logic        inputMinVoltageLoopActive;
      logic        inputCurrentLimitActive;
      logic        systemMinVoltageLoopActive;
      logic        dieTempLoopActive;
      chgst_zone_t batteryTempZone;
   } chgst_stat_a_t;

   // Layout of the charger state status register.
   typedef struct packed {
      chgst_chg_t  chargerStateCode;
      chgst_qual_t inputQualificationCode;
      logic        charging;
      logic        chargeTimerSuspended;
   } chgst_stat_b_t;

   // Serial port receiver and transmitter states.
   typedef enum logic [3:0] {
      BUS_IDLE     = 4'h0,
      BUS_ADDR     = 4'h1,
      BUS_ADDR_ACK = 4'h2,
      BUS_PTR      = 4'h3,
      BUS_PTR_ACK  = 4'h4,
      BUS_WDATA    = 4'h5,
      BUS_WDAT_ACK = 4'h6,
      BUS_RDATA    = 4'h7,
      BUS_RDAT_ACK = 4'h8
   } chgst_bus_t;

endpackage : chgst_pkg

/* File: rtl/chgst_sync.sv */
/*
 * Two-stage synchroniser for a bundle of asynchronous levels, one stage pair
 * per bit.
 * Assumes every input is a level that is stable for several clock periods.
 */
`timescale 1ns/1ns
module chgst_sync #(
   parameter int WIDTH = 19
) (
   input  logic             sys_clk,
   input  logic             rst,
   input  logic             clkEn,
   input  logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // Each bit gets its own pair; only the second stage is visible outside.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : gBit
         logic firstStage_q;   // Metastable stage, read by the second stage only.
         logic secondStage_q;  // Settled copy of the input.

         // The clock enable freezes the pair together with the rest of the block.
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               firstStage_q  <= 1'b0;
               secondStage_q <= 1'b0;
            end else if (clkEn) begin
               firstStage_q  <= asyncIn[i];
               secondStage_q <= firstStage_q;
            end
         end
         assign syncOut[i] = secondStage_q;
      end
   endgenerate

endmodule : chgst_sync

/* File: rtl/chgst_status_regs.sv */
/*
 * Charger status register bank: two read-only status registers and the
 * change-flag register, read through the device's two-wire serial port.
 * Assumes the analog loops deliver their status as asynchronous levels and
 * that the device never stretches or drives the clock line; only the bus master drives it.
 */
`timescale 1ns/1ns
`include "chgst_regs.svh"

// Behaviour
// - Status A bit 7 unused, reads zero
// - Bit 6 shows input minimum-voltage loop
// - Bit 5 shows input current-limit loop
// - Bit 4 shows minimum system-voltage loop
// - Bit 3 shows die temperature loop
// - Zone codes disabled..normal, reserved codes held
// - Cold or hot zone raises temperature fault if thermistor and charger enabled
// - Bits 7:4 carry charger state code
// - Modified done only after modified fast-charge
// - Fault codes reported, reserved codes held
// - Bits 3:2 carry input qualification code
// - No input power accepted while debouncing
// - Status B bit 1 shows charging
// - Status B bit 0 shows timer suspended
// - State and qualification changes latch separate flags
// - Die temperature change latches own flag
module chgst_status_regs
   import chgst_pkg::*;
(
   input  logic       sys_clk,           // System clock, 100 MHz.
   input  logic       rst,               // Asynchronous reset, active high.
   input  logic       clkEn,             // Freezes all state while low.
   input  chgst_raw_t rawStatus,         // Asynchronous status levels.
   input  logic       scl,               // Serial clock pin, input only.
   input  logic       sdaIn,             // Serial data pin level.
   output logic       sdaOut,            // Serial data drive level, always low.
   output logic       sdaOe,             // High while the data pin is pulled low.
   output logic       batteryTempFault,  // Thermistor zone fault level.
   output logic       chargeInputAccept  // Charge input may deliver power.
);

   localparam int RAW_W = $bits(chgst_raw_t);

   // Synchronised copies of the raw status bundle and the two pins.
   logic [RAW_W+1:0] syncBus;     // All asynchronous inputs after two stages.
   chgst_raw_t       rawSync;     // Settled status levels.
   logic             sclSync;     // Settled clock pin.
   logic             sdaSync;     // Settled data pin.
   logic             sclPrev_q;   // Clock pin one cycle ago.
   logic             sdaPrev_q;   // Data pin one cycle ago.

   // Status and flag registers.
   chgst_stat_a_t    statA_q;     // Loop and thermal status.
   chgst_stat_a_t    statA_d;
   chgst_stat_b_t    statB_q;     // Charger state status.
   chgst_stat_b_t    statB_d;
   logic [7:0]       flags_q;     // Latched change flags, cleared by a read.
   logic [7:0]       flags_d;
   logic [7:0]       flagSet;     // Changes seen this cycle.
   logic             modPath_q;   // Fast charge went through a modified state.
   logic             modPath_d;
   logic             faultOut_q;  // Registered temperature fault.
   logic             acceptOut_q; // Registered input power permission.

   // Serial port state.
   chgst_bus_t       busState_q;
   chgst_bus_t       busState_d;
   logic [3:0]       bitCnt_q;    // Bits seen in the current byte.
   logic [3:0]       bitCnt_d;
   logic [7:0]       shift_q;     // Receive and transmit shift register.
   logic [7:0]       shift_d;
   logic [7:0]       pointer_q;   // Register pointer.
   logic [7:0]       pointer_d;
   logic             nack_q;      // Master refused the last read byte.
   logic             nack_d;

   // All asynchronous inputs go through one synchroniser bank.
   chgst_sync #(
      .WIDTH(RAW_W + 2)
   ) uSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .asyncIn ({rawStatus, scl, sdaIn}),
      .syncOut (syncBus)
   );

   assign rawSync = chgst_raw_t'(syncBus[RAW_W+1:2]);
   assign sclSync = syncBus[1];
   assign sdaSync = syncBus[0];

   // Bus events decoded from the settled pins.
   wire sclRise   = sclSync & ~sclPrev_q;
   wire sclFall   = ~sclSync & sclPrev_q;
   wire startSeen = sclSync & sclPrev_q & sdaPrev_q & ~sdaSync;
   wire stopSeen  = sclSync & sclPrev_q & ~sdaPrev_q & sdaSync;
   wire byteDone  = (bitCnt_q == `CHGST_BYTE_BITS);
   wire addrMatch = (shift_q[7:1] == `CHGST_BUS_ADDR);

   // Reserved codes from the analog side are not passed on; the last legal
   // code stays in the register so software never sees a meaningless value.
   wire zoneLegal = (rawSync.batteryTempZone <= ZONE_NORMAL);
   wire chgLegal  = (rawSync.chargerStateCode <= CHG_FAULT_TEMP);
   wire rawIsMod  = (rawSync.chargerStateCode == CHG_CC_MOD) ||
                    (rawSync.chargerStateCode == CHG_CV_MOD) ||
                    (rawSync.chargerStateCode == CHG_TOPOFF_MOD);
   wire rawIsStd  = (rawSync.chargerStateCode == CHG_CC) ||
                    (rawSync.chargerStateCode == CHG_CV) ||
                    (rawSync.chargerStateCode == CHG_TOPOFF) ||
                    (rawSync.chargerStateCode == CHG_OFF) ||
                    (rawSync.chargerStateCode == CHG_PREQUAL);
   wire rawIsDone = (rawSync.chargerStateCode == CHG_DONE) ||
                    (rawSync.chargerStateCode == CHG_DONE_MOD);

   // The modified-path memory is set by a modified state and cleared by off, prequal or a standard state.
   assign modPath_d = rawIsMod ? 1'b1 : (rawIsStd ? 1'b0 : modPath_q);

   // Next value of the loop and thermal status register.
   always_comb begin
      statA_d                            = statA_q;
      statA_d.unusedBit                  = 1'b0;
      statA_d.inputMinVoltageLoopActive  = rawSync.inputMinVoltageLoopActive;
      statA_d.inputCurrentLimitActive    = rawSync.inputCurrentLimitActive;
      statA_d.systemMinVoltageLoopActive = rawSync.systemMinVoltageLoopActive;
      statA_d.dieTempLoopActive          = rawSync.dieTempLoopActive;
      if (zoneLegal) begin
         statA_d.batteryTempZone = chgst_zone_t'(rawSync.batteryTempZone);
      end
   end

   // Next value of the charger state status register.
   always_comb begin
      statB_d                        = statB_q;
      statB_d.inputQualificationCode = rawSync.inputQualificationCode;
      statB_d.charging               = rawSync.charging;
      statB_d.chargeTimerSuspended   = rawSync.chargeTimerSuspended;
      if (rawIsDone) begin
         // The done flavour is decided by the path, not by the raw code.
         statB_d.chargerStateCode = modPath_d ? CHG_DONE_MOD : CHG_DONE;
      end else if (chgLegal) begin
         statB_d.chargerStateCode = chgst_chg_t'(rawSync.chargerStateCode);
      end
   end

   // Change detection against the registered values.
   always_comb begin
      flagSet                   = 8'h00;
      flagSet[`CHGST_FLAG_THM]  = (statA_d.batteryTempZone != statA_q.batteryTempZone);
      flagSet[`CHGST_FLAG_CHG]  =
         (statB_d.chargerStateCode != statB_q.chargerStateCode);
      flagSet[`CHGST_FLAG_CHARGE_INPUT_PIN] =
         (statB_d.inputQualificationCode != statB_q.inputQualificationCode);
      flagSet[`CHGST_FLAG_TJ]   =
         (statA_d.dieTempLoopActive != statA_q.dieTempLoopActive);
      flagSet[`CHGST_FLAG_CTRL] =
         (statA_d.inputMinVoltageLoopActive != statA_q.inputMinVoltageLoopActive) ||
         (statA_d.inputCurrentLimitActive != statA_q.inputCurrentLimitActive);
      flagSet[`CHGST_FLAG_SYS]  =
         statA_d.systemMinVoltageLoopActive & ~statA_q.systemMinVoltageLoopActive;
   end

   // The flag register is cleared when its byte is loaded for transmission.
   wire loadRead  = (busState_q == BUS_ADDR_ACK && sclFall && shift_q[0]) ||
                    (busState_q == BUS_RDAT_ACK && sclFall && !nack_q);
   wire flagRead  = loadRead && (pointer_d == `CHGST_OFS_INT_FLAGS) &&
                    (busState_q == BUS_RDAT_ACK || busState_q == BUS_ADDR_ACK);

   // A change in the clearing cycle survives: the set term is ORed last.
   assign flags_d = (flagRead ? 8'h00 : flags_q) | flagSet;

   // Read multiplexer; unmapped offsets read as zero.
   logic [7:0] readData;
   always_comb begin
      unique case (pointer_d)
         `CHGST_OFS_INT_FLAGS: readData = flags_q;
         `CHGST_OFS_STAT_A:    readData = statA_q;
         `CHGST_OFS_STAT_B:    readData = statB_q;
         default:              readData = 8'h00;
      endcase
   end

   // Serial port sequencing. Bits are sampled on the rising clock edge and
   // driven on the falling edge, so the data line is stable while high.
   always_comb begin
      busState_d = busState_q;
      bitCnt_d   = bitCnt_q;
      shift_d    = shift_q;
      pointer_d  = pointer_q;
      nack_d     = nack_q;
      if (stopSeen) begin
         busState_d = BUS_IDLE;
      end else if (startSeen) begin
         busState_d = BUS_ADDR;
         bitCnt_d   = 4'h0;
      end else if (sclRise) begin
         if (busState_q == BUS_RDAT_ACK) begin
            nack_d = sdaSync;
         end else if (busState_q != BUS_IDLE && !byteDone) begin
            bitCnt_d = bitCnt_q + 4'h1;
            if (busState_q != BUS_RDATA) begin
               shift_d = {shift_q[6:0], sdaSync};
            end
         end
      end else if (sclFall) begin
         unique case (busState_q)
            BUS_IDLE: begin
               busState_d = BUS_IDLE;
            end
            BUS_ADDR: begin
               if (byteDone) begin
                  busState_d = addrMatch ? BUS_ADDR_ACK : BUS_IDLE;
               end
            end
            BUS_ADDR_ACK: begin
               bitCnt_d = 4'h0;
               if (shift_q[0]) begin
                  busState_d = BUS_RDATA;
                  shift_d    = readData;
               end else begin
                  busState_d = BUS_PTR;
               end
            end
            BUS_PTR: begin
               if (byteDone) begin
                  busState_d = BUS_PTR_ACK;
               end
            end
            BUS_PTR_ACK: begin
               pointer_d  = shift_q;
               bitCnt_d   = 4'h0;
               busState_d = BUS_WDATA;
            end
            BUS_WDATA: begin
               if (byteDone) begin
                  busState_d = BUS_WDAT_ACK;
               end
            end
            BUS_WDAT_ACK: begin
               // Written bytes are acknowledged and dropped.
               pointer_d  = pointer_q + 8'h01;
               bitCnt_d   = 4'h0;
               busState_d = BUS_WDATA;
            end
            BUS_RDATA: begin
               if (byteDone) begin
                  busState_d = BUS_RDAT_ACK;
               end else begin
                  shift_d = {shift_q[6:0], 1'b0};
               end
            end
            BUS_RDAT_ACK: begin
               if (nack_q) begin
                  busState_d = BUS_IDLE;
               end else begin
                  pointer_d  = pointer_q + 8'h01;
                  bitCnt_d   = 4'h0;
                  shift_d    = readData;
                  busState_d = BUS_RDATA;
               end
            end
            default: begin
               busState_d = BUS_IDLE;
            end
         endcase
      end
   end

   // Open-drain data line: pulled low for acknowledges and for zero bits.
   wire ackPhase = (busState_q == BUS_ADDR_ACK) || (busState_q == BUS_PTR_ACK) ||
                   (busState_q == BUS_WDAT_ACK);
   assign sdaOut = 1'b0;
   assign sdaOe  = ackPhase || (busState_q == BUS_RDATA && !shift_q[7]);

   // Status registers, reset to zero.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         statA_q   <= chgst_stat_a_t'(`CHGST_RESET_VALUE);
         statB_q   <= chgst_stat_b_t'(`CHGST_RESET_VALUE);
         flags_q   <= `CHGST_RESET_VALUE;
         modPath_q <= 1'b0;
      end else if (clkEn) begin
         statA_q   <= statA_d;
         statB_q   <= statB_d;
         flags_q   <= flags_d;
         modPath_q <= modPath_d;
      end
   end

   // Fault and power-permission outputs follow the synchronised levels.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         faultOut_q  <= 1'b0;
         acceptOut_q <= 1'b0;
      end else if (clkEn) begin
         faultOut_q  <= rawSync.thermistorEnable & rawSync.chargerEnable &
                        (statA_d.batteryTempZone == ZONE_COLD ||
                         statA_d.batteryTempZone == ZONE_HOT);
         // Power is taken only once the input is qualified, never in debounce.
         acceptOut_q <= (statB_d.inputQualificationCode == QUAL_OK);
      end
   end
   assign batteryTempFault  = faultOut_q;
   assign chargeInputAccept = acceptOut_q;

   // Serial port registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busState_q <= BUS_IDLE;
         bitCnt_q   <= 4'h0;
         shift_q    <= 8'h00;
         pointer_q  <= 8'h00;
         nack_q     <= 1'b0;
         sclPrev_q  <= 1'b0;
         sdaPrev_q  <= 1'b0;
      end else if (clkEn) begin
         busState_q <= busState_d;
         bitCnt_q   <= bitCnt_d;
         shift_q    <= shift_d;
         pointer_q  <= pointer_d;
         nack_q     <= nack_d;
         sclPrev_q  <= sclSync;
         sdaPrev_q  <= sdaSync;
      end
   end

endmodule : chgst_status_regs

/* File: test/chgst_status_regs_monitor.sv */
/*
 * Port checker for the charger status bank, bound to chgst_status_regs.
 * Assumes one clock domain, rst active high, and an open-drain data line.
 */
`timescale 1ns/1ns
module chgst_status_regs_monitor
   import chgst_pkg::*;
(
   input logic       sys_clk,
   input logic       rst,
   input logic       clkEn,
   input chgst_raw_t rawStatus,
   input logic       scl,
   input logic       sdaIn,
   input logic       sdaOut,
   input logic       sdaOe,
   input logic       batteryTempFault,
   input logic       chargeInputAccept
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Five quiet cycles cover the two synchroniser stages and the register.
   sequence settled_s;
      (clkEn && $stable(rawStatus))[*5];
   endsequence

   // Reserved zone codes hold the old zone, so are left out.
   wire zoneLegal = rawStatus.batteryTempZone < 3'h6;
   wire zoneBad   = rawStatus.batteryTempZone == 3'h1 || rawStatus.batteryTempZone == 3'h4;
   wire faultExp  = rawStatus.thermistorEnable && rawStatus.chargerEnable && zoneBad;

   chk_fault_level: assert property (
      settled_s ##0 zoneLegal |-> batteryTempFault == faultExp)
      else $error("temperature fault level differs from zone and enables");
   chk_fault_enable: assert property (
      settled_s ##0 !rawStatus.thermistorEnable |-> !batteryTempFault)
      else $error("temperature fault raised with thermistor off");
   chk_accept_okay: assert property (
      settled_s ##0 rawStatus.inputQualificationCode == QUAL_OK |-> chargeInputAccept)
      else $error("qualified input not accepted");
   chk_debounce_refuse: assert property (
      settled_s ##0 rawStatus.inputQualificationCode == QUAL_DEBOUNCE |-> !chargeInputAccept)
      else $error("power accepted while input debounces");
   chk_reset_quiet: assert property (
      disable iff (1'b0) rst [*2] |-> !sdaOe && !batteryTempFault && !chargeInputAccept)
      else $error("outputs active during reset");
   // The device may only take the data line while the serial clock is low.
   chk_drive_late: assert property (
      $rose(sdaOe) |-> !scl && !$past(scl) && !$past(scl, 2))
      else $error("data drive started too soon after clock fall");
   chk_hold_high: assert property (
      scl && $past(scl) && $past(scl, 2) |-> $stable(sdaOe))
      else $error("data drive changed while clock high");
   chk_open_drain: assert property (
      sdaOe |-> !sdaOut)
      else $error("data line driven high");
endmodule : chgst_status_regs_monitor

bind chgst_status_regs chgst_status_regs_monitor u_chgst_status_regs_monitor (
   .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .rawStatus(rawStatus), .scl(scl),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .batteryTempFault(batteryTempFault),
   .chargeInputAccept(chargeInputAccept));

/* File: test/chgst_i2c_host.sv */
/*
 * Behavioural two-wire bus host that reads and writes the status bank.
 * Assumes a pulled-up data line resolved by the bench from sdaPull.
 */
`timescale 1ns/1ns
module chgst_i2c_host
   import chgst_pkg::*;
(
   input  logic sys_clk,
   input  logic sdaLine,
   output logic scl,
   output logic sdaPull
);
   // Both lines idle released, so no false start at power-up.
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end

   // Waits whole cycles; every change lands just after an edge.
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : w

   // One bit: drive o, sample mid-high; half period of 12 cycles exceeds 10.
   task automatic bitx(input logic o, output logic i);
      sdaPull <= !o;
      w(6);
      scl <= 1'b1;
      w(6);
      i = sdaLine;
      w(6);
      scl <= 1'b0;
      w(6);
   endtask : bitx

   // Nine bits MSB first; the ninth is the acknowledge slot.
   task automatic byte9(input logic [8:0] o, output logic [8:0] r);
      for (int k = 8; k >= 0; k--) begin
         bitx(o[k], r[k]);
      end
   endtask : byte9

   // Start or repeated start: data falls while the clock is high.
   task automatic start;
      sdaPull <= 1'b0;
      w(6);
      scl <= 1'b1;
      w(6);
      sdaPull <= 1'b1;
      w(6);
      scl <= 1'b0;
      w(6);
   endtask : start

   // Stop: data rises while the clock is high.
   task automatic stop;
      sdaPull <= 1'b1;
      w(6);
      scl <= 1'b1;
      w(6);
      sdaPull <= 1'b0;
      w(12);
   endtask : stop

   // Reads two bytes from ofs on; ack is high only if both address bytes and ofs were acked.
   task automatic read2(input logic [6:0] ad, input logic [7:0] ofs,
                        output logic [7:0] a, output logic [7:0] b, output logic ack);
      logic [8:0] r;
      start;
      byte9({ad, 1'b0, 1'b1}, r);
      ack = !r[0];
      byte9({ofs, 1'b1}, r);
      ack = ack && !r[0];
      start;
      byte9({ad, 1'b1, 1'b1}, r);
      ack = ack && !r[0];
      byte9({8'hFF, 1'b0}, r);
      a = r[8:1];
      byte9({8'hFF, 1'b1}, r);
      b = r[8:1];
      stop;
   endtask : read2

   // Writes one byte; the unused top bit always goes out as zero.
   task automatic write1(input logic [6:0] ad, input logic [7:0] ofs, input logic [7:0] d,
                         output logic ack);
      logic [8:0] r;
      start;
      byte9({ad, 1'b0, 1'b1}, r);
      ack = !r[0];
      byte9({ofs, 1'b1}, r);
      ack = ack && !r[0];
      byte9({d & 8'h7F, 1'b1}, r);
      ack = ack && !r[0];
      stop;
   endtask : write1
endmodule : chgst_i2c_host

/* File: test/charger_status_registers_tb.sv */
/*
 * Self-checking bench for the charger status bank, driven over the serial port.
 * Assumes chgst_i2c_host as bus host and a pull-up on the data line.
 */
`timescale 1ns/1ns
`include "chgst_regs.svh"
module charger_status_registers_tb
   import chgst_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       clkEn = 1'b1;               // Held high; freezing is not exercised.
   chgst_raw_t rawStatus = '0;             // Raw loop levels into the bank.
   wire        scl, sdaPull, sdaOut, sdaOe, batteryTempFault, chargeInputAccept;
   // Pulled-up line: low when either party pulls it.
   wire        sdaLine = !((sdaOe && !sdaOut) || sdaPull);
   logic [3:0] lp = '0, cs = '0, ec = '0;  // Loops, raw and expected state codes.
   logic [2:0] zn = '0, ez = '0;           // Raw and expected zone.
   logic [1:0] ql = '0;                    // Input qualification.
   logic       ch = 0, su = 0, te = 0, ce = 0;
   logic [7:0] ra, rb;
   logic       ack;
   int         nErrors = 0, cmpCount = 0;

   chgst_status_regs u_chgst_status_regs (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .rawStatus(rawStatus), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .batteryTempFault(batteryTempFault), .chargeInputAccept(chargeInputAccept));
   chgst_i2c_host u_chgst_i2c_host (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl),
      .sdaPull(sdaPull));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Sole end of run.
   task automatic finish_test;
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // Drives the raw levels and lets them cross the synchroniser.
   task automatic apply;
      rawStatus <= chgst_raw_t'({lp, zn, cs, ql, ch, su, te, ce});
      repeat (8) @(posedge sys_clk);
   endtask : apply

   // Reads both status registers and compares them with the expected fields.
   task automatic verify;
      apply;
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_STAT_A, ra, rb, ack);
      check({7'h0, ack}, 8'h01);
      check(ra & 8'h7F, {1'b0, lp, ez});
      check(rb, {ec, ql, ch, su});
   endtask : verify

   // Hang guard: about 1.8 times the expected run length.
   initial begin
      repeat (90000) @(posedge sys_clk);
      nErrors++;
      finish_test;
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      verify;
      for (int i = 0; i < 4; i++) begin
         lp = 4'h1 << i;
         verify;
      end
      // Temperature fault is raised in cold and hot zones with both enables, and not with the thermistor off.
      ql = 2'h3;
      te = 1'b1;
      ce = 1'b1;
      for (int z = 0; z < 6; z++) begin
         zn = 3'(z);
         ez = 3'(z);
         verify;
         check({7'h0, batteryTempFault}, {7'h0, z == 1 || z == 4});
      end
      zn = 3'h6;
      verify;
      te = 1'b0;
      zn = 3'h1;
      ez = 3'h1;
      verify;
      check({7'h0, batteryTempFault}, 8'h00);
      // Done after the modified top-off state must report the modified done.
      for (int c = 0; c < 13; c++) begin
         cs = 4'(c);
         ec = (c == 8) ? 4'h9 : 4'(c);
         verify;
      end
      cs = 4'hD;
      verify;
      cs = 4'h2;
      ec = 4'h2;
      verify;
      cs = 4'h9;
      ec = 4'h8;
      verify;
      for (int q = 0; q < 4; q++) begin
         ql = 2'(q);
         verify;
         check({7'h0, chargeInputAccept}, {7'h0, q == 3});
      end
      ch = 1'b1;
      verify;
      su = 1'b1;
      verify;
      u_chgst_i2c_host.write1(`CHGST_BUS_ADDR, `CHGST_OFS_STAT_A, 8'hFF, ack);
      check({7'h0, ack}, 8'h01);
      u_chgst_i2c_host.write1(`CHGST_BUS_ADDR, `CHGST_OFS_STAT_B, 8'h00, ack);
      verify;
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, 8'h10, ra, rb, ack);
      check(ra | rb, 8'h00);
      u_chgst_i2c_host.read2(7'h15, `CHGST_OFS_STAT_A, ra, rb, ack);
      check({7'h0, ack}, 8'h00);
      // Change flags: clear, then one source at a time.
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_INT_FLAGS, ra, rb, ack);
      cs = 4'h4;
      apply;
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_INT_FLAGS, ra, rb, ack);
      check(ra, 8'h02);
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_INT_FLAGS, ra, rb, ack);
      check(ra, 8'h00);
      ql = 2'h2;
      apply;
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_INT_FLAGS, ra, rb, ack);
      check(ra, 8'h04);
      lp = lp ^ 4'h1;
      apply;
      u_chgst_i2c_host.read2(`CHGST_BUS_ADDR, `CHGST_OFS_INT_FLAGS, ra, rb, ack);
      check(ra, 8'h08);
      finish_test;
   end
endmodule : charger_status_registers_tb
